//--- rtl/sas_pkg.sv
//------------------------------------------------------------------------------
// Purpose : shared constants and types of the sar adc sequencer
// Assumes : byte-wide register port, 16-bit addresses
// Notes   : all offsets, fields, resets and counts live here
//------------------------------------------------------------------------------
package sas_pkg;

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam int unsigned      ADDR_W        = 16;
  localparam logic [15:0]      RESULT_ADDR   = 16'h0070;
  localparam logic [15:0]      CTRL_ADDR     = 16'h0071;
  localparam logic [15:0]      EVT_STAT_ADDR = 16'h0072;
  localparam logic [15:0]      EVT_CLR_ADDR  = 16'h0073;
  localparam logic [15:0]      EVT_EN_ADDR   = 16'h0074;

  // ---------------------------------------------------------------------------
  // control/status fields
  // ---------------------------------------------------------------------------
  localparam int unsigned      DONE_BIT      = 7;
  localparam int unsigned      RSVD_HI_BIT   = 6;
  localparam int unsigned      ON_BIT        = 5;
  localparam int unsigned      RSVD_LO_BIT   = 4;
  localparam int unsigned      CH_MSB        = 3;
  localparam logic [7:0]       CTRL_RESET    = 8'h00;
  localparam logic [7:0]       RESULT_RESET  = 8'h00;

  // event bits
  localparam int unsigned      EVT_W         = 2;
  localparam int unsigned      EVT_ABORT_BIT = 0;
  localparam int unsigned      EVT_OVRN_BIT  = 1;
  localparam logic [1:0]       EVT_RESET     = 2'h0;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int unsigned      ADC_CLK_DIV   = 2;
  localparam int unsigned      SAMPLE_PER    = 4;
  localparam int unsigned      STEP_CNT      = 8;
  localparam int unsigned      CONV_PER      = 12;
  localparam int unsigned      SAMPLE_CYC    = SAMPLE_PER * ADC_CLK_DIV;
  localparam int unsigned      CONV_CYC      = CONV_PER * ADC_CLK_DIV;
  localparam logic [4:0]       CYC_SAMPLE_END = 5'(SAMPLE_CYC - 1);
  localparam logic [4:0]       CYC_LAST      = 5'(CONV_CYC - 1);

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SAS_IDLE    = 2'b00,
    SAS_SAMPLE  = 2'b01,
    SAS_CONVERT = 2'b10
  } sas_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } sas_bus_req_t;

  typedef struct packed {
    logic        power;
    logic        sample;
    logic [3:0]  channel;
    logic [7:0]  trial;
  } sas_ana_t;

endpackage

//--- rtl/sas_sar_step.sv
//------------------------------------------------------------------------------
// Purpose : successive approximation register, one bit per step
// Assumes : comparator high means input at or above the trial code
// Notes   : code starts at mid scale, msb first
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module sas_sar_step (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  // step control
  input  wire logic       clear_i,
  input  wire logic       decide_i,
  input  wire logic       cmp_i,
  // results
  output logic [7:0]      trial_o,
  output logic [7:0]      value_o,
  output logic            final_o
);
  import sas_pkg::*;

  logic [7:0] code;
  logic [7:0] mask;

  // keep the trial bit only while the input is not below it
  function automatic logic [7:0] keep_bit(input logic [7:0] c, input logic [7:0] m,
                                          input logic hi);
    keep_bit = hi ? c : (c & ~m);
  endfunction

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      code <= 8'h00;
      mask <= 8'h00;
    end else if (clear_i) begin
      code <= 8'h80;
      mask <= 8'h80;
    end else if (decide_i) begin
      code <= keep_bit(code, mask, cmp_i) | (mask >> 1);
      mask <= mask >> 1;
    end
  end

  assign trial_o = code;
  assign value_o = keep_bit(code, mask, cmp_i);
  assign final_o = decide_i && (mask == 8'h01);

endmodule // sas_sar_step

//--- rtl/sas_sequencer.sv
//------------------------------------------------------------------------------
// Purpose : control logic of an 8-bit sar adc with 16-way input mux
// Assumes : comparator output registered on clk_sys_i by the analog core;
//           halt request comes from the clock controller on clk_sys_i
// Notes   : converter clock is clk_sys_i / 2, no separate domain
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module sas_sequencer (
  // clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   nrst_i,
  // register port
  input  wire sas_pkg::sas_bus_req_t  bus_i,
  output logic [7:0]                  rdata_o,
  // power mode
  input  wire logic                   halt_i,
  // analog core
  input  wire logic                   cmp_i,
  output sas_pkg::sas_ana_t           ana_o,
  // interrupt
  output logic                        irq_o
);
  import sas_pkg::*;

  // ---------------------------------------------------------------------------
  // register port decode
  // ---------------------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    hit = (a == r);
  endfunction

  logic       ctrl_wr;
  logic       res_rd;
  logic       clr_wr;
  logic       en_wr;
  logic       next_on;
  logic       run;
  logic       advance;

  logic       converter_on;
  logic [3:0] channel_select;
  logic       conversion_done_flag;
  logic [7:0] result_register;
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_enable;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] next_status;
  logic       power;
  logic       irq;
  logic [7:0] rdata;

  sas_state_t state;
  logic [4:0] cyc;
  logic       in_sample;
  logic       in_convert;
  logic       sample_q;
  logic       sar_clear;
  logic       sar_decide;
  logic       sar_final;
  logic [7:0] sar_trial;
  logic [7:0] sar_value;

  assign ctrl_wr = bus_i.wr && hit(bus_i.addr, CTRL_ADDR);
  assign res_rd  = bus_i.rd && hit(bus_i.addr, RESULT_ADDR);
  assign clr_wr  = bus_i.wr && hit(bus_i.addr, EVT_CLR_ADDR);
  assign en_wr   = bus_i.wr && hit(bus_i.addr, EVT_EN_ADDR);

  // ---------------------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------------------
  // reserved bits 6 and 4 are not stored, so they always read zero
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      converter_on   <= CTRL_RESET[ON_BIT];
      channel_select <= CTRL_RESET[CH_MSB:0];
    end else if (ctrl_wr) begin
      converter_on   <= bus_i.wdata[ON_BIT];
      channel_select <= bus_i.wdata[CH_MSB:0];
    end
  end

  // a write that sets the on bit takes effect in the same cycle
  assign next_on = ctrl_wr ? bus_i.wdata[ON_BIT] : converter_on;
  // wait mode has no input here: the converter simply keeps running
  assign run     = next_on && !halt_i;
  assign advance = run && !ctrl_wr && (state != SAS_IDLE);

  // ---------------------------------------------------------------------------
  // conversion sequence
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= SAS_IDLE;
      cyc   <= 5'h00;
    end else if (!run) begin
      state <= SAS_IDLE;
      cyc   <= 5'h00;
    end else if (ctrl_wr || state == SAS_IDLE) begin
      state <= SAS_SAMPLE;
      cyc   <= 5'h00;
    end else if (cyc == CYC_LAST) begin
      state <= SAS_SAMPLE;
      cyc   <= 5'h00;
    end else begin
      case (state)
        SAS_SAMPLE: begin
          if (cyc == CYC_SAMPLE_END) begin
            state <= SAS_CONVERT;
          end
        end
        default: begin
          state <= state;
        end
      endcase
      cyc <= cyc + 5'h01;
    end
  end

  assign in_sample  = (state == SAS_SAMPLE);
  assign in_convert = (state == SAS_CONVERT);

  // registered copy of the sample phase, so the switch pin comes from a flop
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sample_q <= 1'b0;
    end else if (!run) begin
      sample_q <= 1'b0;
    end else if (ctrl_wr || state == SAS_IDLE || cyc == CYC_LAST) begin
      sample_q <= 1'b1;
    end else if (in_sample && cyc == CYC_SAMPLE_END) begin
      sample_q <= 1'b0;
    end
  end

  // trial code goes out when the sample switch opens
  assign sar_clear  = advance && in_sample && (cyc == CYC_SAMPLE_END);
  // decide at the last cpu cycle of each converter clock
  assign sar_decide = advance && in_convert && cyc[0];

  sas_sar_step u_sar (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .clear_i   (sar_clear),
    .decide_i  (sar_decide),
    .cmp_i     (cmp_i),
    .trial_o   (sar_trial),
    .value_o   (sar_value),
    .final_o   (sar_final)
  );

  // ---------------------------------------------------------------------------
  // result and done flag
  // ---------------------------------------------------------------------------
  // saturation at both ends falls out of the search: all-high gives ff, all-low 00
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      result_register <= RESULT_RESET;
    end else if (sar_final) begin
      result_register <= sar_value;
    end
  end

  // set wins over a same-cycle result read
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conversion_done_flag <= CTRL_RESET[DONE_BIT];
    end else if (sar_final) begin
      conversion_done_flag <= 1'b1;
    end else if (ctrl_wr || res_rd) begin
      conversion_done_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // events and interrupt
  // ---------------------------------------------------------------------------
  // completion itself never interrupts; only aborts and lost results do
  always_comb begin
    evt_set                = '0;
    evt_set[EVT_ABORT_BIT] = ctrl_wr && (state != SAS_IDLE);
    evt_set[EVT_OVRN_BIT]  = sar_final && conversion_done_flag && !res_rd;
    next_status            = evt_set | (evt_status & ~(clr_wr ? bus_i.wdata[EVT_W-1:0]
                                                              : '0));
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      evt_status <= EVT_RESET;
    end else begin
      evt_status <= next_status;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      evt_enable <= EVT_RESET;
    end else if (en_wr) begin
      evt_enable <= bus_i.wdata[EVT_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_status & evt_enable);
    end
  end

  // ---------------------------------------------------------------------------
  // read data and analog outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata <= 8'h00;
    end else if (!bus_i.rd) begin
      rdata <= 8'h00;
    end else if (hit(bus_i.addr, RESULT_ADDR)) begin
      rdata <= result_register;
    end else if (hit(bus_i.addr, CTRL_ADDR)) begin
      rdata <= {conversion_done_flag, 1'b0, converter_on, 1'b0, channel_select};
    end else if (hit(bus_i.addr, EVT_STAT_ADDR)) begin
      rdata <= {6'h00, evt_status};
    end else if (hit(bus_i.addr, EVT_EN_ADDR)) begin
      rdata <= {6'h00, evt_enable};
    end else begin
      rdata <= 8'h00;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      power <= 1'b0;
    end else begin
      power <= run;
    end
  end

  assign rdata_o       = rdata;
  assign irq_o         = irq;
  assign ana_o.power   = power;
  assign ana_o.sample  = sample_q;
  assign ana_o.channel = channel_select;
  assign ana_o.trial   = sar_trial;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  logic all_high;
  logic all_low;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      all_high <= 1'b0;
      all_low  <= 1'b0;
    end else if (sar_clear) begin
      all_high <= 1'b1;
      all_low  <= 1'b1;
    end else if (sar_decide) begin
      all_high <= all_high && cmp_i;
      all_low  <= all_low && !cmp_i;
    end
  end

  sequence s_ctrl_on_write;
    ctrl_wr && bus_i.wdata[ON_BIT] && !halt_i;
  endsequence

  sequence s_fresh_start;
    in_sample && (cyc == 5'h00) && !conversion_done_flag;
  endsequence

  sequence s_back_to_back;
    sar_final && run && !ctrl_wr;
  endsequence

  done_set_a: assert property (sar_final |=> conversion_done_flag)
    else $error("done flag not set after conversion end");
  result_hold_a: assert property (!sar_final |=> $stable(result_register))
    else $error("result changed outside conversion end");
  conv_length_a: assert property (sar_final |-> $past(in_sample, 16) &&
      $past(in_convert, 15) && $past(in_sample, 23))
    else $error("conversion did not last twelve converter clocks");
  repeat_conv_a: assert property (s_back_to_back |=> in_sample && (cyc == 5'h00))
    else $error("conversion did not repeat back to back");
  write_restart_a: assert property (s_ctrl_on_write |=> s_fresh_start)
    else $error("control write did not restart conversion");
  done_clear_a: assert property (res_rd && !sar_final |=> !conversion_done_flag)
    else $error("result read did not clear done flag");
  off_stop_a: assert property (ctrl_wr && !bus_i.wdata[ON_BIT] |=>
      (state == SAS_IDLE) && !power)
    else $error("converter kept running after switch off");
  halt_stop_a: assert property (halt_i |=> (state == SAS_IDLE) && !$rose(sar_final))
    else $error("converter ran during halt");
  ctrl_read_a: assert property (bus_i.rd && hit(bus_i.addr, CTRL_ADDR) |=>
      (rdata_o[RSVD_HI_BIT] == 1'b0) && (rdata_o[RSVD_LO_BIT] == 1'b0) &&
      (rdata_o[ON_BIT] == $past(converter_on)))
    else $error("control register read wrong");
  full_scale_a: assert property (sar_final && all_high && cmp_i |=>
      result_register == 8'hff)
    else $error("full scale input did not read ff");
  zero_scale_a: assert property (sar_final && all_low && !cmp_i |=>
      result_register == 8'h00)
    else $error("zero input did not read 00");
  channel_out_a: assert property (ctrl_wr |=> ana_o.channel == $past(bus_i.wdata[3:0]))
    else $error("channel select not driven to mux");
  sample_open_a: assert property (sar_clear ##1 !ctrl_wr |->
      !ana_o.sample ##1 !ana_o.sample)
    else $error("sample switch closed during conversion");
  sample_flop_a: assert property (ana_o.sample == in_sample)
    else $error("sample switch out of step with phase");
  result_read_a: assert property (bus_i.rd && hit(bus_i.addr, RESULT_ADDR) |=>
      rdata_o == $past(result_register))
    else $error("result register read wrong");
  power_on_a: assert property (s_ctrl_on_write |=> ana_o.power)
    else $error("converter not powered after switch on");
  no_done_irq_a: assert property (!(|evt_enable) |=> !irq_o)
    else $error("interrupt raised with no event enabled");
  abort_evt_a: assert property (evt_set[EVT_ABORT_BIT] |=> evt_status[EVT_ABORT_BIT])
    else $error("abort event lost");

endmodule // sas_sequencer

//--- verif/sas_ana_model.sv
// Purpose : analog mux, sample capacitor and comparator in front of the sequencer
// Assumes : comparator output registered on clk_sys_i
// Notes   : each input level is given as the ideal 8-bit code of that pin
`timescale 1ns/1ps
module sas_ana_model (
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              nrst_i,
  // from sequencer, plus the pin levels
  input  wire sas_pkg::sas_ana_t ana_i,
  input  wire logic [15:0][7:0]  level_i,
  // to sequencer
  output logic                   cmp_o
);
  import sas_pkg::*;

  logic [7:0] held;

  // charge is kept after sampling, so a late pin change must not leak in
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      held <= 8'h00;
    end else if (ana_i.power && ana_i.sample) begin
      held <= level_i[ana_i.channel];
    end
  end

  // unpowered comparator is garbage: toggle rather than hold a value
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmp_o <= 1'b0;
    end else if (!ana_i.power) begin
      cmp_o <= ~cmp_o;
    end else begin
      cmp_o <= (held >= ana_i.trial);
    end
  end
endmodule // sas_ana_model

//--- verif/tb_top.sv
// Purpose : self-checking bench of the sar adc sequencer
// Assumes : register port strobes driven right after rising edges
// Notes   : random pin levels from a fixed seed, rails forced at ch 0 and 15
`timescale 1ns/1ps
module tb_top;
  import sas_pkg::*;

  logic             clk_sys_i   = 1'b0;
  logic             nrst_i      = 1'b0;
  sas_bus_req_t     bus         = '0;
  logic             halt        = 1'b0;
  logic [15:0][7:0] level       = '0;
  logic [7:0]       rdata;
  logic             cmp;
  sas_ana_t         ana;
  sas_ana_t         ana_s;
  logic             irq;
  logic             irq_s;
  logic [7:0]       rd_v;
  int               fail_count  = 0;
  int               checks_done = 0;
  int               cyc         = 0;

  always #50 clk_sys_i = ~clk_sys_i;

  sas_sequencer dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .bus_i(bus), .rdata_o(rdata),
                     .halt_i(halt), .cmp_i(cmp), .ana_o(ana), .irq_o(irq));
  sas_ana_model model (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ana_i(ana),
                       .level_i(level), .cmp_o(cmp));

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic finish_test();
    $display("mismatches %0d, checks %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard, far above the fewer than one thousand cycles the run needs
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] exp_ctrl(input logic done, input logic on,
                                          input logic [3:0] ch);
    return {done, 1'b0, on, 1'b0, ch};
  endfunction

  // ideal binary search against the held level
  function automatic logic [7:0] sar_code(input logic [7:0] lv);
    logic [7:0] t;
    t = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      if (lv >= (t | (8'h01 << b))) t = t | (8'h01 << b);
    end
    return t;
  endfunction

  // tasks start just after a rising edge and end on one
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus.wr    <= 1'b1;
    bus.addr  <= a;
    bus.wdata <= d;
    @(posedge clk_sys_i);
    bus.wr <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    bus.rd   <= 1'b1;
    bus.addr <= a;
    @(posedge clk_sys_i);
    bus.rd <= 1'b0;
    @(negedge clk_sys_i);
    d     = rdata;
    irq_s = irq;
    ana_s = ana;
    @(posedge clk_sys_i);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    rd(CTRL_ADDR, rd_v);
    while (rd_v[DONE_BIT] !== 1'b1 && n < 40) begin
      rd(CTRL_ADDR, rd_v);
      n++;
    end
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic [7:0] v;
    int         hi;
    int         lo;
    void'($urandom(10007));
    repeat (16) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(RESULT_ADDR, rd_v); check8(rd_v, RESULT_RESET);
    rd(CTRL_ADDR, rd_v); check8(rd_v, CTRL_RESET);
    rd(16'h0075, rd_v); check8(rd_v, 8'h00);
    check8({7'h0, ana_s.power}, 8'h00);
    for (int c = 0; c < 16; c++) begin
      v = (c == 0) ? 8'h00 : (c == 15) ? 8'hff : 8'($urandom);
      level[c] <= v;
      wr(CTRL_ADDR, exp_ctrl(1'b0, 1'b1, 4'(c)));
      wait_done();
      check8(rd_v, exp_ctrl(1'b1, 1'b1, 4'(c)));
      check8({4'h0, ana_s.channel}, 8'(c));
      check8({7'h0, irq_s}, 8'h00);
      rd(RESULT_ADDR, rd_v); check8(rd_v, sar_code(v));
      rd(CTRL_ADDR, rd_v); check8(rd_v, exp_ctrl(1'b0, 1'b1, 4'(c)));
    end
    // result is read-only and holds until a later conversion ends
    wr(RESULT_ADDR, 8'h33);
    level[15] <= 8'h3c;
    rd(RESULT_ADDR, rd_v); check8(rd_v, 8'hff);
    wait_done();
    rd(RESULT_ADDR, rd_v);
    wait_done();
    rd(RESULT_ADDR, rd_v); check8(rd_v, sar_code(8'h3c));
    // phase lengths seen on the sample switch
    hi = 0;
    lo = 0;
    for (int i = 0; i < 40 && ana.sample === 1'b1; i++) @(negedge clk_sys_i);
    for (int i = 0; i < 40 && ana.sample !== 1'b1; i++) @(negedge clk_sys_i);
    while (ana.sample === 1'b1 && hi < 40) begin
      hi++;
      @(negedge clk_sys_i);
    end
    while (ana.sample !== 1'b1 && lo < 40) begin
      lo++;
      @(negedge clk_sys_i);
    end
    check8(8'(hi), 8'(SAMPLE_CYC));
    check8(8'(hi + lo), 8'(CONV_CYC));
    @(posedge clk_sys_i);
    // abort in mid-conversion, with the abort event raising the interrupt
    wr(EVT_CLR_ADDR, 8'h03);
    wr(EVT_EN_ADDR, 8'h01);
    repeat (5) @(posedge clk_sys_i);
    wr(CTRL_ADDR, 8'h25);
    rd(CTRL_ADDR, rd_v); check8(rd_v, 8'h25);
    check8({7'h0, ana_s.sample}, 8'h01);
    rd(EVT_STAT_ADDR, rd_v); check8(rd_v & 8'h01, 8'h01);
    check8({7'h0, irq_s}, 8'h01);
    wr(EVT_EN_ADDR, 8'h00);
    rd(EVT_STAT_ADDR, rd_v); check8(rd_v & 8'h01, 8'h01);
    check8({7'h0, irq_s}, 8'h00);
    wr(EVT_CLR_ADDR, 8'h01);
    wr(EVT_EN_ADDR, 8'h01);
    rd(EVT_EN_ADDR, rd_v); check8(rd_v, 8'h01);
    rd(EVT_STAT_ADDR, rd_v); check8(rd_v & 8'h01, 8'h00);
    check8({7'h0, irq_s}, 8'h00);
    wr(EVT_EN_ADDR, 8'h00);
    // switched off: no power, no further conversions
    wr(CTRL_ADDR, 8'h05);
    rd(CTRL_ADDR, rd_v); check8(rd_v, 8'h05);
    check8({7'h0, ana_s.power}, 8'h00);
    repeat (60) @(posedge clk_sys_i);
    rd(CTRL_ADDR, rd_v); check8(rd_v, 8'h05);
    // halt stops the converter, release resumes it
    wr(CTRL_ADDR, 8'h27);
    halt <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rd(CTRL_ADDR, rd_v); check8({7'h0, ana_s.power}, 8'h00);
    repeat (60) @(posedge clk_sys_i);
    rd(CTRL_ADDR, rd_v); check8(rd_v, 8'h27);
    halt <= 1'b0;
    wait_done();
    check8(rd_v, 8'ha7);
    rd(RESULT_ADDR, rd_v); check8(rd_v, sar_code(level[7]));
    finish_test();
  end
endmodule // tb_top
